// File: core/twee_device.sv
/*
 device end: slave protocol, page buffer, self-timed write, 2048 x 8 array.
 assumes: link lines and select pins are asynchronous; master clocks all transfers.
*/
module twee_device
   import twee_pkg::*;
#(
   parameter int unsigned WRITE_CYCLE_COUNT = WRITE_CYCLE_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   twee_if.device link,
   input wire logic device_select_pin_low,
   input wire logic device_select_pin_mid_inverted,
   input wire logic device_select_pin_high,
   output logic write_busy,
   output logic selected
);

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_DEVADDR = 6'h02,
      ST_WORDADDR = 6'h04,
      ST_WRDATA = 6'h08,
      ST_RDDATA = 6'h10,
      ST_WRITING = 6'h20
   } dev_state_t;

   dev_state_t state_q;
   logic [2:0] scl_sync_q;
   logic [2:0] sda_sync_q;
   logic [2:0] sel_meta_q;
   logic [2:0] sel_sync_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic [CNT_W-1:0] cnt_q;
   logic [DATA_W-1:0] shift_q;
   logic [DATA_W-1:0] tx_q;
   logic [ADDR_W-1:0] addr_q;
   logic sda_oe_n_q;
   logic [DATA_W-1:0] page_buf_q [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] page_vld_q;
   logic [WTIMER_W-1:0] wtimer_q;
   logic write_done;
   logic [DATA_W-1:0] mem_q [MEM_WORDS];
   logic [DATA_W-1:0] rd_word;

   function automatic logic sel_match(input logic [DATA_W-1:0] b, input logic [2:0] pins);
      sel_match = (b[SA_TYPE] == SA_TYPE_VAL)
         && (b[SA_SEL_HIGH] == pins[2]) && (b[SA_SEL_MID] == ~pins[1])
         && (b[SA_SEL_LOW] == pins[0]);
   endfunction : sel_match

   // link and pin synchronisers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         scl_sync_q <= 3'h7;
         sda_sync_q <= 3'h7;
      end else begin
         scl_sync_q <= {scl_sync_q[1:0], link.scl};
         sda_sync_q <= {sda_sync_q[1:0], link.sda_line};
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sel_meta_q <= 3'h0;
         sel_sync_q <= 3'h0;
      end else begin
         sel_meta_q <= {device_select_pin_high, device_select_pin_mid_inverted,
            device_select_pin_low};
         sel_sync_q <= sel_meta_q;
      end
   end

   // master supplies the clock; its edges and the start and stop conditions move the protocol
   assign scl_rise = scl_sync_q[1] & ~scl_sync_q[2];
   assign scl_fall = ~scl_sync_q[1] & scl_sync_q[2];
   assign start_det = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[2] & ~sda_sync_q[1];
   assign stop_det = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[2] & sda_sync_q[1];
   assign rd_word = mem_q[addr_q];

   // self-timed write cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wtimer_q <= '0;
      end else if (state_q == ST_WRITING) begin
         wtimer_q <= wtimer_q + 1'b1;
      end else begin
         wtimer_q <= '0;
      end
   end
   assign write_done = (state_q == ST_WRITING)
      && (wtimer_q == WTIMER_W'(WRITE_CYCLE_COUNT - 1));

   // array commit at end of write cycle
   always_ff @(posedge core_clk) begin
      if (write_done) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (page_vld_q[i]) begin
               mem_q[{addr_q[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= page_buf_q[i];
            end
         end
      end
   end

   // page buffer
   always_ff @(posedge core_clk) begin
      if (state_q == ST_WRDATA && scl_fall && cnt_q == BIT_LAST && !start_det && !stop_det) begin
         page_buf_q[addr_q[PAGE_W-1:0]] <= shift_q;
      end
   end

   // protocol engine
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         shift_q <= '0;
         tx_q <= '0;
         addr_q <= '0;
         sda_oe_n_q <= 1'b1;
         page_vld_q <= '0;
      end else if (state_q == ST_WRITING) begin
         sda_oe_n_q <= 1'b1;
         if (write_done) begin
            state_q <= ST_IDLE;
            page_vld_q <= '0;
         end
      end else if (start_det) begin
         state_q <= ST_DEVADDR;
         cnt_q <= '0;
         sda_oe_n_q <= 1'b1;
      end else if (stop_det) begin
         sda_oe_n_q <= 1'b1;
         if (state_q == ST_WRDATA && |page_vld_q) begin
            state_q <= ST_WRITING;
         end else begin
            state_q <= ST_IDLE;
         end
      end else if (state_q == ST_RDDATA) begin
         if (scl_rise && cnt_q < BIT_LAST) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (scl_rise && cnt_q == BIT_LAST) begin
            if (!sda_sync_q[1]) begin
               cnt_q <= BIT_ACK_END;
            end else begin
               state_q <= ST_IDLE;
            end
         end else if (scl_fall && cnt_q >= BIT_FIRST_SHIFT && cnt_q < BIT_LAST) begin
            sda_oe_n_q <= tx_q[DATA_W-2];
            tx_q <= {tx_q[DATA_W-2:0], 1'b0};
         end else if (scl_fall && cnt_q == BIT_LAST) begin
            sda_oe_n_q <= 1'b1;
         end else if (scl_fall && cnt_q == BIT_ACK_END) begin
            tx_q <= rd_word;
            sda_oe_n_q <= rd_word[DATA_W-1];
            addr_q <= addr_q + 1'b1;
            cnt_q <= '0;
         end
      end else if (state_q != ST_IDLE) begin
         if (scl_rise && cnt_q < BIT_LAST) begin
            shift_q <= {shift_q[DATA_W-2:0], sda_sync_q[1]};
            cnt_q <= cnt_q + 1'b1;
         end else if (scl_fall && cnt_q == BIT_LAST) begin
            cnt_q <= BIT_ACK_END;
            if (state_q == ST_DEVADDR && !sel_match(shift_q, sel_sync_q)) begin
               state_q <= ST_IDLE;
            end else begin
               sda_oe_n_q <= 1'b0;
               if (state_q == ST_DEVADDR && shift_q[SA_RW] != RW_READ) begin
                  addr_q[ADDR_W-1:DATA_W] <= shift_q[SA_AHI_MSB:SA_AHI_LSB];
                  page_vld_q <= '0;
               end else if (state_q == ST_WORDADDR) begin
                  addr_q[DATA_W-1:0] <= shift_q;
               end else if (state_q == ST_WRDATA) begin
                  page_vld_q[addr_q[PAGE_W-1:0]] <= 1'b1;
                  addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + 1'b1;
               end
            end
         end else if (scl_fall && cnt_q == BIT_ACK_END) begin
            sda_oe_n_q <= 1'b1;
            cnt_q <= '0;
            if (state_q == ST_DEVADDR && shift_q[SA_RW] == RW_READ) begin
               state_q <= ST_RDDATA;
               tx_q <= rd_word;
               sda_oe_n_q <= rd_word[DATA_W-1];
               addr_q <= addr_q + 1'b1;
            end else if (state_q == ST_DEVADDR) begin
               state_q <= ST_WORDADDR;
            end else begin
               state_q <= ST_WRDATA;
            end
         end
      end
   end

   assign link.d_sda_o = 1'b0;
   assign link.d_sda_oe_n = sda_oe_n_q;
   assign write_busy = (state_q == ST_WRITING);
   assign selected = (state_q != ST_IDLE) && (state_q != ST_WRITING) && (state_q != ST_DEVADDR);

endmodule : twee_device

// File: core/twee_if.sv
/*
 interface: the two-wire link between master and memory device.
 assumes: data line is open drain with a pull-up, resolved here.
*/
interface twee_if;
   logic scl;
   logic m_sda_o;
   logic m_sda_oe_n;
   logic d_sda_o;
   logic d_sda_oe_n;
   logic sda_line;

   // wired-and with pull-up
   assign sda_line = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);

   modport master (output scl, output m_sda_o, output m_sda_oe_n, input sda_line);
   modport device (input scl, output d_sda_o, output d_sda_oe_n, input sda_line);
endinterface : twee_if

// File: core/twee_master.sv
/*
 master end: issues start, stop, byte write and byte read on the link.
 assumes: one command at a time from the user side; the link clock is made here.
*/
module twee_master
   import twee_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   twee_if.master link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire cmd_t cmd_op,
   input wire logic [DATA_W-1:0] cmd_data,
   input wire logic cmd_nack,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_data,
   output logic rsp_ack
);

   typedef enum logic [1:0] {
      MS_IDLE = 2'h1,
      MS_RUN = 2'h2
   } mst_state_t;

   mst_state_t state_q;
   cmd_t op_q;
   logic [DIV_W-1:0] div_q;
   logic tick;
   logic [1:0] phase_q;
   logic [CNT_W-1:0] bit_q;
   logic [DATA_W:0] tx_q;
   logic [DATA_W:0] rx_q;
   logic scl_q;
   logic sda_oe_n_q;
   logic [1:0] sda_sync_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sda_sync_q <= 2'h3;
      end else begin
         sda_sync_q <= {sda_sync_q[0], link.sda_line};
      end
   end

   // quarter-period enable
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_q <= '0;
      end else if (state_q != MS_RUN || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end
   assign tick = (state_q == MS_RUN) && (div_q == DIV_W'(QTR_CYC - 1));

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= MS_IDLE;
         op_q <= CMD_STOP;
         phase_q <= '0;
         bit_q <= '0;
         tx_q <= '0;
         rx_q <= '0;
         scl_q <= 1'b1;
         sda_oe_n_q <= 1'b1;
         rsp_valid <= 1'b0;
         rsp_data <= '0;
         rsp_ack <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         case (state_q)
            MS_IDLE: begin
               if (cmd_valid) begin
                  state_q <= MS_RUN;
                  op_q <= cmd_op;
                  phase_q <= '0;
                  bit_q <= '0;
                  tx_q <= (cmd_op == CMD_WRITE) ? {cmd_data, 1'b1} : {8'hff, cmd_nack};
               end
            end
            MS_RUN: begin
               if (tick) begin
                  phase_q <= phase_q + 1'b1;
                  case (op_q)
                     CMD_START: begin
                        case (phase_q)
                           2'h0: sda_oe_n_q <= 1'b1;
                           2'h1: scl_q <= 1'b1;
                           2'h2: sda_oe_n_q <= 1'b0;
                           default: begin
                              scl_q <= 1'b0;
                              state_q <= MS_IDLE;
                           end
                        endcase
                     end
                     CMD_STOP: begin
                        case (phase_q)
                           2'h0: sda_oe_n_q <= 1'b0;
                           2'h1: scl_q <= 1'b1;
                           2'h2: sda_oe_n_q <= 1'b1;
                           default: state_q <= MS_IDLE;
                        endcase
                     end
                     default: begin
                        case (phase_q)
                           2'h0: sda_oe_n_q <= tx_q[DATA_W];
                           2'h1: scl_q <= 1'b1;
                           2'h2: rx_q <= {rx_q[DATA_W-1:0], sda_sync_q[1]};
                           default: begin
                              scl_q <= 1'b0;
                              tx_q <= {tx_q[DATA_W-1:0], 1'b1};
                              bit_q <= bit_q + 1'b1;
                              if (bit_q == BIT_LAST) begin
                                 state_q <= MS_IDLE;
                                 rsp_valid <= 1'b1;
                                 rsp_data <= rx_q[DATA_W:1];
                                 rsp_ack <= ~rx_q[0];
                              end
                           end
                        endcase
                     end
                  endcase
               end
            end
            default: state_q <= MS_IDLE;
         endcase
      end
   end

   assign cmd_ready = (state_q == MS_IDLE);
   assign link.scl = scl_q;
   assign link.m_sda_o = 1'b0;
   assign link.m_sda_oe_n = sda_oe_n_q;

endmodule : twee_master

// File: core/twee_pkg.sv
/*
 package: constants shared by both ends of the two-wire memory link.
 assumes: a single 250 MHz core clock on each end.
*/
package twee_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 11;
   localparam int unsigned MEM_WORDS = 2048;
   localparam int unsigned PAGE_BYTES = 16;
   localparam int unsigned PAGE_W = 4;
   localparam int unsigned CNT_W = 4;
   // slave address field positions
   localparam int unsigned SA_TYPE = 7;
   localparam int unsigned SA_SEL_HIGH = 6;
   localparam int unsigned SA_SEL_MID = 5;
   localparam int unsigned SA_SEL_LOW = 4;
   localparam int unsigned SA_AHI_MSB = 3;
   localparam int unsigned SA_AHI_LSB = 1;
   localparam int unsigned SA_RW = 0;
   localparam logic SA_TYPE_VAL = 1'b1;
   localparam logic RW_READ = 1'b1;
   // bit counter marks
   localparam logic [CNT_W-1:0] BIT_LAST = 4'h8;
   localparam logic [CNT_W-1:0] BIT_ACK_END = 4'h9;
   localparam logic [CNT_W-1:0] BIT_FIRST_SHIFT = 4'h1;
   // timing
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned WRITE_CYCLE_NS = 5_000_000;
   localparam int unsigned WRITE_CYCLE_CYC = WRITE_CYCLE_NS / CLK_PERIOD_NS;
   localparam int unsigned WTIMER_W = 21;
   localparam int unsigned SCL_PERIOD_NS = 128;
   localparam int unsigned QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
   localparam int unsigned DIV_W = 8;
   // master commands
   typedef enum logic [1:0] {
      CMD_START = 2'h0,
      CMD_STOP = 2'h1,
      CMD_WRITE = 2'h2,
      CMD_READ = 2'h3
   } cmd_t;
endpackage : twee_pkg

// File: tb/test_two_wire_eeprom_slave.sv
/*
 bench: master end drives the device end across the shared link.
 assumes: short write cycle parameter; inputs change 1 ns after each rising edge.
*/
module test_two_wire_eeprom_slave;
   timeunit 1ns;
   timeprecision 100ps;
   import twee_pkg::*;
   localparam int unsigned WCC = 2000;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_nack = 1'b0;
   cmd_t cmd_op = CMD_START;
   logic [7:0] cmd_data = 8'h00;
   logic [2:0] pins = 3'h0;
   logic cmd_ready, rsp_valid, rsp_ack, write_busy, selected;
   logic [7:0] rsp_data;
   logic [8:0] exp_q[$];
   logic [8:0] exp_v;
   logic [7:0] mem [0:2047];
   logic [31:0] lfsr = 32'h0001_8103;
   logic [10:0] pg;
   int errors = 0;
   int compares = 0;
   twee_if link();
   twee_device #(.WRITE_CYCLE_COUNT(WCC)) twee_device_inst (.core_clk(core_clk), .rst(rst),
      .link(link), .device_select_pin_low(pins[0]), .device_select_pin_mid_inverted(pins[1]),
      .device_select_pin_high(pins[2]), .write_busy(write_busy), .selected(selected));
   twee_master twee_master_inst (.core_clk(core_clk), .rst(rst), .link(link),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
      .cmd_nack(cmd_nack), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
   twee_link_sva #(.WRITE_CYCLE_COUNT(WCC)) twee_link_sva_inst (.core_clk(core_clk),
      .rst(rst), .scl(link.scl), .d_sda_oe_n(link.d_sda_oe_n), .sda_line(link.sda_line),
      .write_busy(write_busy), .selected(selected));
   initial forever #2 core_clk = ~core_clk;
   function automatic logic [31:0] next_rand(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : next_rand
   function automatic logic [7:0] sa(logic [10:0] a, logic rw, logic bad);
      return {SA_TYPE_VAL, pins[2], ~pins[1] ^ bad, pins[0], a[10:8], rw};
   endfunction : sa
   task automatic check_byte(string name, logic [8:0] exp, logic [8:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : check_byte
   task automatic check_bit(string name, logic exp, logic got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask : check_bit
   task automatic final_report();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   task automatic issue(cmd_t op, logic [7:0] d, logic nack, logic ack);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 1000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (op == CMD_WRITE) exp_q.push_back({ack, d});
      if (op == CMD_READ) exp_q.push_back({!nack, d});
      cmd_op = op;
      cmd_data = d;
      cmd_nack = nack;
      cmd_valid = 1'b1;
      @(posedge core_clk);
      #1;
      cmd_valid = 1'b0;
   endtask : issue
   task automatic wait_busy(logic lvl);
      int n;
      n = 0;
      while (write_busy !== lvl && n < 3000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
   endtask : wait_busy
   // response watcher
   always @(negedge core_clk) begin
      if (rsp_valid === 1'b1) begin
         exp_v = exp_q.size() > 0 ? exp_q.pop_front() : 9'hxxx;
         check_byte("ack,byte", exp_v, {rsp_ack, rsp_data});
      end
   end
   initial begin
      repeat (5) @(posedge core_clk);
      #1;
      rst = 1'b0;
      lfsr = next_rand(lfsr);
      pins = lfsr[2:0];
      pg = {lfsr[13:7], 4'h2};
      // foreign select bits
      issue(CMD_START, 8'h00, 1'b0, 1'b0);
      issue(CMD_WRITE, sa(pg, 1'b0, 1'b1), 1'b0, 1'b0);
      issue(CMD_STOP, 8'h00, 1'b0, 1'b0);
      check_bit("selected", 1'b0, selected);
      // eighteen byte page write, wraps
      issue(CMD_START, 8'h00, 1'b0, 1'b0);
      issue(CMD_WRITE, sa(pg, 1'b0, 1'b0), 1'b0, 1'b1);
      issue(CMD_WRITE, pg[7:0], 1'b0, 1'b1);
      for (int i = 0; i < 18; i++) begin
         lfsr = next_rand(lfsr);
         mem[{pg[10:4], pg[3:0] + i[3:0]}] = lfsr[7:0];
         issue(CMD_WRITE, lfsr[7:0], 1'b0, 1'b1);
      end
      check_bit("selected", 1'b1, selected);
      issue(CMD_STOP, 8'h00, 1'b0, 1'b0);
      wait_busy(1'b1);
      check_bit("write_busy", 1'b1, write_busy);
      // polling during the write cycle
      issue(CMD_START, 8'h00, 1'b0, 1'b0);
      issue(CMD_WRITE, sa(pg, 1'b0, 1'b0), 1'b0, 1'b0);
      issue(CMD_STOP, 8'h00, 1'b0, 1'b0);
      issue(CMD_START, 8'h00, 1'b0, 1'b0);
      issue(CMD_WRITE, sa(pg, 1'b1, 1'b0), 1'b0, 1'b0);
      issue(CMD_STOP, 8'h00, 1'b0, 1'b0);
      wait_busy(1'b0);
      // current address read after the page
      issue(CMD_START, 8'h00, 1'b0, 1'b0);
      issue(CMD_WRITE, sa(pg, 1'b1, 1'b0), 1'b0, 1'b1);
      for (int i = 4; i < 16; i++)
         issue(CMD_READ, mem[{pg[10:4], i[3:0]}], i == 15, 1'b0);
      issue(CMD_STOP, 8'h00, 1'b0, 1'b0);
      // random read of the wrapped head
      issue(CMD_START, 8'h00, 1'b0, 1'b0);
      issue(CMD_WRITE, sa(pg, 1'b0, 1'b0), 1'b0, 1'b1);
      issue(CMD_WRITE, {pg[7:4], 4'h0}, 1'b0, 1'b1);
      issue(CMD_START, 8'h00, 1'b0, 1'b0);
      issue(CMD_WRITE, sa(pg, 1'b1, 1'b0), 1'b0, 1'b1);
      for (int i = 0; i < 4; i++)
         issue(CMD_READ, mem[{pg[10:4], i[3:0]}], i == 3, 1'b0);
      issue(CMD_STOP, 8'h00, 1'b0, 1'b0);
      // stop with no data byte
      issue(CMD_START, 8'h00, 1'b0, 1'b0);
      issue(CMD_WRITE, sa(pg, 1'b0, 1'b0), 1'b0, 1'b1);
      issue(CMD_WRITE, pg[7:0], 1'b0, 1'b1);
      issue(CMD_STOP, 8'h00, 1'b0, 1'b0);
      repeat (80) @(posedge core_clk);
      check_bit("write_busy", 1'b0, write_busy);
      issue(CMD_START, 8'h00, 1'b0, 1'b0);
      issue(CMD_WRITE, sa(pg, 1'b0, 1'b0), 1'b0, 1'b1);
      issue(CMD_STOP, 8'h00, 1'b0, 1'b0);
      repeat (100) @(posedge core_clk);
      check_bit("queue drained", 1'b1, exp_q.size() == 0);
      final_report();
   end
   initial begin
      repeat (60000) @(posedge core_clk);
      errors++;
      final_report();
   end
endmodule : test_two_wire_eeprom_slave

// File: tb/twee_link_sva.sv
/*
 checker: wire timing and busy behaviour of the two-wire link.
 assumes: placed in the bench top beside the interface, one core clock.
*/
module twee_link_sva #(
   parameter int unsigned WRITE_CYCLE_COUNT = 2000
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic scl,
   input wire logic d_sda_oe_n,
   input wire logic sda_line,
   input wire logic write_busy,
   input wire logic selected
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic scl_d_q;
   logic sda_d_q;
   logic [3:0] rise_cnt_q;
   logic [3:0] stop_age_q;
   logic [31:0] busy_cnt_q;
   sequence stop_s;
      scl && $past(scl) && $rose(sda_line);
   endsequence
   sequence addr_bit_s;
      scl && $past(scl) && rise_cnt_q inside {[1:8]};
   endsequence
   // previous link levels
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         scl_d_q <= 1'b1;
         sda_d_q <= 1'b1;
      end else begin
         scl_d_q <= scl;
         sda_d_q <= sda_line;
      end
   end
   // clock rises since the last start
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) rise_cnt_q <= 4'hf;
      else if (scl && scl_d_q && sda_d_q && !sda_line) rise_cnt_q <= 4'h0;
      else if (scl && !scl_d_q && rise_cnt_q != 4'hf) rise_cnt_q <= rise_cnt_q + 4'h1;
   end
   // cycles since the last stop
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) stop_age_q <= 4'hf;
      else if (scl && scl_d_q && !sda_d_q && sda_line) stop_age_q <= 4'h0;
      else if (stop_age_q != 4'hf) stop_age_q <= stop_age_q + 4'h1;
   end
   // length of the internal write
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) busy_cnt_q <= 32'h0000_0000;
      else if (write_busy) busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
      else busy_cnt_q <= 32'h0000_0000;
   end
   dev_hold_low_a: assert property ($changed(d_sda_oe_n) |-> !scl)
      else $error("device data changed with clock high");
   busy_silent_a: assert property (write_busy |-> d_sda_oe_n && !selected)
      else $error("device answered while busy");
   busy_len_a: assert property ($fell(write_busy) |->
      busy_cnt_q == WRITE_CYCLE_COUNT)
      else $error("write cycle length wrong");
   busy_after_stop_a: assert property ($rose(write_busy) |-> stop_age_q < 4'hc)
      else $error("write cycle began without a stop");
   addr_silent_a: assert property (addr_bit_s |-> d_sda_oe_n)
      else $error("device drove data during address bits");
   stop_released_a: assert property (stop_s |-> $past(d_sda_oe_n, 16))
      else $error("stop while device drove data");
   reset_idle_a: assert property ($fell(rst) |->
      scl && sda_line && !write_busy && !selected)
      else $error("link not idle after reset");
   scl_high_a: assert property ($rose(scl) |-> scl[*8])
      else $error("clock high phase too short");
   sel_addr_a: assert property ($rose(selected) |-> rise_cnt_q inside {[8:9]})
      else $error("selected rose outside address acknowledge");
endmodule : twee_link_sva
